// ===== hw/dpf_pkg.sv
// Behaviour
// [R01] Tile 0, shared 1: register word paints all
// [R02] Tile 1, shared 0: fetch pattern per plane
// [R03] Tile 1, shared 1: one fetched word, all planes
// [R04] Pattern word advances per row; shared per row
// [R05] Read from base, wrap after count words
// [R06] Next plane pattern adds stride words
// [R07] Paint selected planes below top count only
// [R08] Boundary by given colour or seed mismatch
// [R09] Left edge point painted per flag
// [R10] Right edge point painted per flag
// [R11] Copy reads end to start when swapped
// [R12] Copy writes mirrored when flag set
// [R13] Copy turns area half way round
// [R14] Decode plane transfer mode two bits
// [R15] Rotation copy fills missed points per flag
// [R16] Direction 1 put, 0 get
// [R17] Speed bit picks normal or fast
// [R18] Host: fast fill only plain replace
// [R19] Host: fast copy only plain single source
// [R20] Pattern bit chosen by x modulo 16
// [R21] Unsupported fast falls back to normal
`default_nettype none
package dpf_pkg;
  // ==========================
  // Widths
  localparam int AW = 24;
  localparam int PW = 16;
  localparam int PLW = 5;
  // ==========================
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_PCOUNT = 8'h04;
  localparam logic [7:0] A_PBASE = 8'h08;
  localparam logic [7:0] A_PSTRIDE = 8'h0c;
  localparam logic [7:0] A_PTOP = 8'h10;
  localparam logic [7:0] A_PSEL = 8'h14;
  localparam logic [7:0] A_XSPAN = 8'h18;
  localparam logic [7:0] A_YSPAN = 8'h1c;
  localparam logic [7:0] A_BCOL = 8'h20;
  localparam logic [7:0] A_GO = 8'h24;
  localparam logic [7:0] A_STATUS = 8'h28;
  // ==========================
  // Control field positions
  localparam int B_TILE = 0;
  localparam int B_SHARED = 1;
  localparam int B_BMATCH = 2;
  localparam int B_LEFT = 3;
  localparam int B_RIGHT = 4;
  localparam int B_SWAP = 5;
  localparam int B_MIRROR = 6;
  localparam int B_HALF = 7;
  localparam int B_TPM = 8;
  localparam int B_FILLM = 10;
  localparam int B_PUT = 11;
  localparam int B_FAST = 12;
  localparam int B_OP = 13;
  localparam int B_CLIP = 15;
  localparam int B_REPL = 16;
  localparam int CTRL_W = 17;
  localparam logic [CTRL_W-1:0] CTRL_RST = 17'h00002;
  // ==========================
  // Operation kinds and transfer modes
  typedef enum logic [1:0] {
    DPF_OP_FILL = 2'b00,
    DPF_OP_COPY = 2'b01,
    DPF_OP_XCOPY = 2'b10,
    DPF_OP_PUTGET = 2'b11
  } dpf_op_t;
  localparam logic [1:0] TPM_SINGLE = 2'b00;
  localparam logic [1:0] TPM_MSRC = 2'b01;
  localparam logic [1:0] TPM_MDST = 2'b10;
  localparam logic [1:0] TPM_MBOTH = 2'b11;
  // ==========================
  // Timing: idle cycles between pixels at normal speed
  localparam logic [1:0] NORMAL_GAP = 2'h1;
  localparam logic [PLW-1:0] MAX_PLANES = 5'h10;
endpackage
`default_nettype wire

// ===== hw/dpf_pat_addr.sv
`default_nettype none
module dpf_pat_addr (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Steps
  input wire logic row_clr,
  input wire logic row_step,
  input wire logic plane_clr,
  input wire logic plane_step,
  // Settings
  input wire logic [dpf_pkg::AW-1:0] base,
  input wire logic [dpf_pkg::AW-1:0] stride,
  input wire logic [dpf_pkg::PW-1:0] count,
  // Result
  output logic [dpf_pkg::AW-1:0] addr
);
  import dpf_pkg::*;
  logic [PW-1:0] row_q;
  logic [PW-1:0] row_d;
  logic [AW-1:0] off_q;
  logic [AW-1:0] off_d;
  wire row_last = (row_q + 16'h0001 >= count);
  // Wrap back to the first pattern word after the last
  assign row_d = row_clr ? 16'h0000 : (row_step ? (row_last ? 16'h0000 : row_q + 16'h0001) : row_q); // R05 R04
  assign off_d = plane_clr ? 24'h000000 : (plane_step ? off_q + stride : off_q); // R06
  assign addr = base + off_q + {8'h00, row_q}; // R05
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      row_q <= 16'h0000;
      off_q <= 24'h000000;
    end else begin
      row_q <= row_d;
      off_q <= off_d;
    end
  end
endmodule
`default_nettype wire

// ===== hw/dpf_engine.sv
// The address map and register access over APB were left to the implementer.
`default_nettype none
module dpf_engine (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pattern read port to display memory
  output logic mem_rd_req,
  output logic [dpf_pkg::AW-1:0] mem_rd_addr,
  input wire logic mem_rd_ack,
  input wire logic [dpf_pkg::PW-1:0] mem_rd_data,
  // Pixel write port
  output logic pix_valid,
  input wire logic pix_ready,
  output logic [3:0] pix_plane,
  output logic [15:0] pix_x,
  output logic [15:0] pix_y,
  output logic pix_bit,
  // Boundary probe
  input wire logic [15:0] probe_colour,
  output logic is_boundary,
  // Copy and transfer decode
  output logic copy_read_reverse,
  output logic copy_mirror,
  output logic copy_half_turn,
  output logic multi_source,
  output logic multi_dest,
  output logic fill_missed,
  output logic put_transfer,
  output logic get_transfer,
  output logic fast_active,
  output logic busy
);
  import dpf_pkg::*;
  // ==========================
  // State
  typedef enum logic [2:0] {
    DPF_IDLE = 3'b000,
    DPF_SCAN = 3'b001,
    DPF_FETCH = 3'b010,
    DPF_PIX = 3'b011,
    DPF_ROW = 3'b100
  } dpf_state_t;
  dpf_state_t st_q;
  dpf_state_t st_d;
  logic [CTRL_W-1:0] ctrl_q;
  logic [PW-1:0] pcount_q;
  logic [AW-1:0] pbase_q;
  logic [AW-1:0] pstride_q;
  logic [PW-1:0] ptop_q;
  logic [PW-1:0] psel_q;
  logic [31:0] xspan_q;
  logic [31:0] yspan_q;
  logic [31:0] bcol_q;
  logic [PLW-1:0] plane_q;
  logic [PLW-1:0] plane_d;
  logic [15:0] x_q;
  logic [15:0] x_d;
  logic [15:0] y_q;
  logic [15:0] y_d;
  logic [15:0] rows_q;
  logic [15:0] rows_d;
  logic [PW-1:0] pat_q;
  logic [PW-1:0] pat_d;
  logic have_q;
  logic have_d;
  logic [1:0] gap_q;
  logic [1:0] gap_d;
  // ==========================
  // APB decode
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire hit_ctrl = (paddr == A_CTRL);
  wire hit_pcount = (paddr == A_PCOUNT);
  wire hit_pbase = (paddr == A_PBASE);
  wire hit_pstride = (paddr == A_PSTRIDE);
  wire hit_ptop = (paddr == A_PTOP);
  wire hit_psel = (paddr == A_PSEL);
  wire hit_xspan = (paddr == A_XSPAN);
  wire hit_yspan = (paddr == A_YSPAN);
  wire hit_bcol = (paddr == A_BCOL);
  wire hit_go = (paddr == A_GO);
  wire hit_status = (paddr == A_STATUS);
  wire hit_any = hit_ctrl | hit_pcount | hit_pbase | hit_pstride | hit_ptop | hit_psel
    | hit_xspan | hit_yspan | hit_bcol | hit_go | hit_status;
  // Settings are locked while an operation runs
  wire wr_cfg = wr & (st_q == DPF_IDLE);
  wire start = wr_cfg & hit_go & pwdata[0];
  assign pready = 1'b1;
  assign pslverr = acc & ~hit_any;
  // ==========================
  // Flag decode
  wire tile = ctrl_q[B_TILE];
  wire shared = ctrl_q[B_SHARED];
  wire [1:0] op = ctrl_q[B_OP+1:B_OP];
  wire [1:0] tpm = ctrl_q[B_TPM+1:B_TPM];
  assign copy_read_reverse = ctrl_q[B_SWAP]; // R11
  assign copy_mirror = ctrl_q[B_MIRROR]; // R12
  assign copy_half_turn = ctrl_q[B_HALF]; // R13
  assign multi_source = (tpm == TPM_MSRC) | (tpm == TPM_MBOTH); // R14
  assign multi_dest = (tpm == TPM_MDST) | (tpm == TPM_MBOTH); // R14
  assign fill_missed = ctrl_q[B_FILLM]; // R15
  assign put_transfer = ctrl_q[B_PUT]; // R16
  assign get_transfer = ~ctrl_q[B_PUT]; // R16
  // Fast only where it is safe; otherwise run at normal speed
  wire fill_ok = (op == DPF_OP_FILL) & ctrl_q[B_REPL] & ~ctrl_q[B_CLIP] & ~tile; // R18
  wire copy_ok = (op == DPF_OP_COPY) & ctrl_q[B_REPL] & ~multi_source; // R19
  assign fast_active = ctrl_q[B_FAST] & (fill_ok | copy_ok); // R17 R21
  // Seed-colour mode treats every other colour as boundary
  assign is_boundary = ctrl_q[B_BMATCH] ? (probe_colour != bcol_q[31:16])
    : (probe_colour == bcol_q[15:0]); // R08
  // ==========================
  // Pattern addressing
  wire row_clr = start;
  wire row_step;
  wire plane_clr;
  wire plane_step;
  dpf_pat_addr u_dpf_pat_addr (
    .clk(clk),
    .rst(rst),
    .row_clr(row_clr),
    .row_step(row_step),
    .plane_clr(plane_clr),
    .plane_step(plane_step),
    .base(pbase_q),
    .stride(pstride_q),
    .count(pcount_q),
    .addr(mem_rd_addr)
  );
  // ==========================
  // Plane walk
  wire [PLW-1:0] top_lim = (ptop_q > {11'h000, MAX_PLANES}) ? MAX_PLANES : ptop_q[PLW-1:0];
  wire planes_done = (plane_q >= top_lim); // R07
  wire plane_sel = psel_q[plane_q[3:0]]; // R07
  // Per-plane mode fetches every plane, shared fetches once per row
  wire need_fetch = tile & (~shared | ~have_q); // R02 R03 R04
  wire [15:0] xs = xspan_q[15:0];
  wire [15:0] xe = xspan_q[31:16];
  wire at_left = (x_q == xs);
  wire at_right = (x_q == xe);
  wire skip_pt = (at_left & ~ctrl_q[B_LEFT]) | (at_right & ~ctrl_q[B_RIGHT]); // R09 R10
  wire gap_ok = (gap_q == 2'h0);
  wire pix_done = gap_ok & (skip_pt | pix_ready);
  wire in_pix = (st_q == DPF_PIX);
  wire step_plane_skip = (st_q == DPF_SCAN) & ~planes_done & ~plane_sel;
  wire step_plane_pix = in_pix & pix_done & at_right;
  // Shared patterns keep a zero plane offset; only per-plane mode strides
  assign plane_step = (step_plane_skip | step_plane_pix) & ~shared; // R06 R03
  assign row_step = (st_q == DPF_ROW); // R04
  assign plane_clr = start | (st_q == DPF_ROW);
  assign mem_rd_req = (st_q == DPF_FETCH);
  assign pix_valid = in_pix & gap_ok & ~skip_pt; // R09 R10
  assign pix_plane = plane_q[3:0];
  assign pix_x = x_q;
  assign pix_y = y_q;
  assign pix_bit = pat_q[x_q[3:0]]; // R20
  assign busy = (st_q != DPF_IDLE);
  // ==========================
  // Sequencer
  always_comb begin
    st_d = st_q;
    plane_d = plane_q;
    x_d = x_q;
    y_d = y_q;
    rows_d = rows_q;
    pat_d = pat_q;
    have_d = have_q;
    gap_d = gap_q;
    unique case (st_q)
      DPF_IDLE: begin
        if (start) begin
          st_d = DPF_SCAN;
          plane_d = 5'h00;
          y_d = yspan_q[15:0];
          rows_d = yspan_q[31:16];
          have_d = 1'b0;
          if (yspan_q[31:16] == 16'h0000) begin
            st_d = DPF_IDLE;
          end
        end
      end
      DPF_SCAN: begin
        if (planes_done) begin
          st_d = DPF_ROW;
        end else if (!plane_sel) begin
          plane_d = plane_q + 5'h01;
        end else if (need_fetch) begin
          st_d = DPF_FETCH;
        end else begin
          st_d = DPF_PIX;
          x_d = xs;
          gap_d = 2'h0;
          if (!tile) begin
            pat_d = pcount_q; // R01
          end
        end
      end
      DPF_FETCH: begin
        if (mem_rd_ack) begin
          pat_d = mem_rd_data; // R02 R03
          have_d = 1'b1;
          st_d = DPF_PIX;
          x_d = xs;
          gap_d = 2'h0;
        end
      end
      DPF_PIX: begin
        if (!gap_ok) begin
          gap_d = gap_q - 2'h1;
        end else if (pix_done) begin
          gap_d = fast_active ? 2'h0 : NORMAL_GAP; // R17 R21
          if (at_right) begin
            st_d = DPF_SCAN;
            plane_d = plane_q + 5'h01;
          end else begin
            x_d = x_q + 16'h0001;
          end
        end
      end
      DPF_ROW: begin
        plane_d = 5'h00;
        have_d = 1'b0;
        y_d = y_q + 16'h0001;
        rows_d = rows_q - 16'h0001;
        st_d = (rows_q == 16'h0001) ? DPF_IDLE : DPF_SCAN;
      end
      default: begin
        st_d = DPF_IDLE;
      end
    endcase
  end
  // ==========================
  // Read data
  wire [31:0] status_w = {y_q, 7'h00, plane_q, 2'h0, fast_active, busy};
  assign prdata = hit_ctrl ? {15'h0000, ctrl_q}
    : hit_pcount ? {16'h0000, pcount_q}
    : hit_pbase ? {8'h00, pbase_q}
    : hit_pstride ? {8'h00, pstride_q}
    : hit_ptop ? {16'h0000, ptop_q}
    : hit_psel ? {16'h0000, psel_q}
    : hit_xspan ? xspan_q
    : hit_yspan ? yspan_q
    : hit_bcol ? bcol_q
    : hit_status ? status_w
    : 32'h00000000;
  // ==========================
  // Registers
  wire we_ctrl = wr_cfg & hit_ctrl;
  wire we_pcount = wr_cfg & hit_pcount;
  wire we_pbase = wr_cfg & hit_pbase;
  wire we_pstride = wr_cfg & hit_pstride;
  wire we_ptop = wr_cfg & hit_ptop;
  wire we_psel = wr_cfg & hit_psel;
  wire we_xspan = wr_cfg & hit_xspan;
  wire we_yspan = wr_cfg & hit_yspan;
  wire we_bcol = wr_cfg & hit_bcol;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
    end else if (we_ctrl) begin
      ctrl_q <= pwdata[CTRL_W-1:0];
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pcount_q <= 16'h0000;
    end else if (we_pcount) begin
      pcount_q <= pwdata[PW-1:0];
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pbase_q <= 24'h000000;
    end else if (we_pbase) begin
      pbase_q <= pwdata[AW-1:0];
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pstride_q <= 24'h000000;
    end else if (we_pstride) begin
      pstride_q <= pwdata[AW-1:0];
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptop_q <= 16'h0000;
    end else if (we_ptop) begin
      ptop_q <= pwdata[PW-1:0];
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      psel_q <= 16'h0000;
    end else if (we_psel) begin
      psel_q <= pwdata[PW-1:0];
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xspan_q <= 32'h00000000;
    end else if (we_xspan) begin
      xspan_q <= pwdata;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      yspan_q <= 32'h00000000;
    end else if (we_yspan) begin
      yspan_q <= pwdata;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bcol_q <= 32'h00000000;
    end else if (we_bcol) begin
      bcol_q <= pwdata;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= DPF_IDLE;
      plane_q <= 5'h00;
      x_q <= 16'h0000;
      y_q <= 16'h0000;
      rows_q <= 16'h0000;
      pat_q <= 16'h0000;
      have_q <= 1'b0;
      gap_q <= 2'h0;
    end else begin
      st_q <= st_d;
      plane_q <= plane_d;
      x_q <= x_d;
      y_q <= y_d;
      rows_q <= rows_d;
      pat_q <= pat_d;
      have_q <= have_d;
      gap_q <= gap_d;
    end
  end
endmodule
`default_nettype wire

// ===== dv/dpf_props.sv
`default_nettype none
module dpf_props
  import dpf_pkg::*;
(
  // Clock, reset, bus
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // Engine
  input wire logic busy,
  input wire logic pix_valid,
  input wire logic pix_ready,
  input wire logic [15:0] pix_x,
  input wire logic [3:0] pix_plane,
  input wire logic mem_rd_req,
  input wire logic mem_rd_ack,
  input wire logic [AW-1:0] mem_rd_addr,
  // Decode
  input wire logic put_transfer,
  input wire logic get_transfer,
  input wire logic copy_read_reverse,
  input wire logic copy_mirror,
  input wire logic multi_source,
  input wire logic multi_dest,
  input wire logic fast_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire ctrl_wr = psel && penable && pwrite && paddr == A_CTRL && !busy;
  // ==========================
  // Properties
  AST_PIX_HOLD: assert property (pix_valid && !pix_ready |=>
    pix_valid && $stable(pix_x) && $stable(pix_plane)) else $error("pixel dropped");
  AST_MEM_HOLD: assert property (mem_rd_req && !mem_rd_ack |=>
    mem_rd_req && $stable(mem_rd_addr)) else $error("fetch dropped");
  AST_MEM_DONE: assert property (mem_rd_req && mem_rd_ack |=> !mem_rd_req)
    else $error("fetch not closed");
  AST_DIR: assert property (ctrl_wr |=> put_transfer == $past(pwdata[B_PUT])
    && get_transfer != $past(pwdata[B_PUT])) else $error("direction wrong");
  AST_TPM: assert property (ctrl_wr |=> multi_source == $past(pwdata[B_TPM])
    && multi_dest == $past(pwdata[B_TPM+1])) else $error("plane mode wrong");
  AST_READ_REV: assert property (ctrl_wr |=> copy_read_reverse == $past(pwdata[B_SWAP]))
    else $error("read order wrong");
  AST_MIRROR: assert property (ctrl_wr |=> copy_mirror == $past(pwdata[B_MIRROR]))
    else $error("mirror wrong");
  AST_GAP: assert property (pix_valid && pix_ready && !fast_active |=> !pix_valid)
    else $error("no gap at normal speed");
  AST_SLOW_WRITE: assert property (ctrl_wr && !pwdata[B_FAST] |=> !fast_active[*2])
    else $error("fast without request");
  AST_IDLE_QUIET: assert property (!busy |-> !pix_valid && !mem_rd_req)
    else $error("activity while idle");
  cover property (pix_valid && pix_ready && fast_active);
  cover property (mem_rd_req && mem_rd_ack);
  cover property (pix_valid && !pix_ready);
endmodule
bind dpf_engine dpf_props u_dpf_props (.clk, .rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .busy, .pix_valid, .pix_ready, .pix_x, .pix_plane, .mem_rd_req, .mem_rd_ack,
  .mem_rd_addr, .put_transfer, .get_transfer, .copy_read_reverse, .copy_mirror,
  .multi_source, .multi_dest, .fast_active);
`default_nettype wire

// ===== dv/dpf_mem_model.sv
`default_nettype none
module dpf_mem_model
  import dpf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pattern read port
  input wire logic req,
  input wire logic [AW-1:0] addr,
  output logic ack,
  output logic [PW-1:0] data,
  // Answer delay in cycles
  input wire logic [3:0] lat
);
  logic [3:0] cnt_q;
  // Data toggles outside the acknowledge cycle so stale words never pass
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
      cnt_q <= 4'h0;
      data <= 16'h0;
    end else begin
      ack <= 1'b0;
      data <= ~data;
      cnt_q <= (req && !ack) ? cnt_q + 4'h1 : 4'h0;
      if (req && !ack && cnt_q >= lat) begin
        ack <= 1'b1;
        data <= {addr[7:0], ~addr[7:0]};
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/dpf_engine_bench.sv
`default_nettype none
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] %s expected %0h seen %0h", n, e, a); end end
module dpf_engine_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import dpf_pkg::*;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pix_ready = 0, err;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [15:0] probe_colour = 0, pix_x, pix_y;
  logic [3:0] pix_plane, lat = 0;
  logic pready, pslverr, mem_rd_req, mem_rd_ack, pix_valid, pix_bit, is_boundary, busy;
  logic copy_read_reverse, copy_mirror, copy_half_turn, multi_source, multi_dest;
  logic fill_missed, put_transfer, get_transfer, fast_active, ef;
  logic [AW-1:0] mem_rd_addr;
  logic [PW-1:0] mem_rd_data;
  logic [36:0] q[$], ep;
  logic [31:0] c;
  int miscompares = 0, num_checks = 0, cyc = 0;
  dpf_engine u_dpf_engine (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .mem_rd_req, .mem_rd_addr, .mem_rd_ack, .mem_rd_data, .pix_valid,
    .pix_ready, .pix_plane, .pix_x, .pix_y, .pix_bit, .probe_colour, .is_boundary,
    .copy_read_reverse, .copy_mirror, .copy_half_turn, .multi_source, .multi_dest,
    .fill_missed, .put_transfer, .get_transfer, .fast_active, .busy);
  dpf_mem_model u_dpf_mem_model (.clk, .rst, .req(mem_rd_req), .addr(mem_rd_addr),
    .ack(mem_rd_ack), .data(mem_rd_data), .lat);
  always #2 clk = ~clk;
  // ==========================
  // Timeout, stalls and pixel scoreboard
  always @(posedge clk) begin
    cyc++;
    pix_ready <= ($urandom % 4) != 0;
    if (cyc == 40000) begin
      miscompares++;
      test_done();
    end
  end
  always @(posedge clk) begin
    if (pix_valid === 1'b1 && pix_ready === 1'b1) begin
      ep = q.size() ? q.pop_front() : 'x;
      `CHK("pixel", ep, {pix_plane, pix_x, pix_y, pix_bit})
    end
  end
  task automatic test_done();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Expected pixels: rows, then selected planes below the top count, then x
  task automatic paint(input logic [31:0] c, pc, base, strd, top, sel, xs, xe, ys, rows);
    logic [23:0] a;
    logic [15:0] w;
    logic [31:0] v[7];
    v = '{pc, base, strd, top, sel, {xe[15:0], xs[15:0]}, {rows[15:0], ys[15:0]}};
    for (int r = 0; r < rows; r++)
      for (int p = 0; p < (top > 16 ? 16 : top); p++)
        if (sel[p]) begin
          a = base[23:0] + (c[B_SHARED] ? 24'h0 : 24'(p) * strd[23:0]) + 24'(pc ? r % pc : 0);
          w = c[B_TILE] ? {a[7:0], ~a[7:0]} : pc[15:0];
          for (int x = xs; x <= xe; x++)
            if (!((x == xs && !c[B_LEFT]) || (x == xe && !c[B_RIGHT])))
              q.push_back({p[3:0], x[15:0], ys[15:0] + r[15:0], w[x[3:0]]});
        end
    apb(1'b1, A_CTRL, c);
    foreach (v[i]) apb(1'b1, A_PCOUNT + 8'(4 * i), v[i]);
    apb(1'b1, A_GO, 32'h1);
    while (busy === 1'b1) @(posedge clk);
    repeat (4) @(posedge clk);
    `CHK("left_over", 0, q.size())
  endtask
  // ==========================
  // Main sequence
  initial begin
    void'($urandom(32'h8718));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, A_CTRL, 32'h0);
    `CHK("ctrl_rst", 32'(CTRL_RST), rd)
    `CHK("get_rst", 1'b1, get_transfer)
    apb(1'b0, 8'h3c, 32'h0);
    `CHK("slverr", 1'b1, err)
    paint(32'h0a, $urandom, 0, 0, 4, 16'h0015, 14, 19, 5, 2);
    lat <= 4'h3;
    paint(32'h13, 3, 24'h100, 24'h20, 3, 6, 0, 3, 0, 5);
    lat <= 4'h0;
    paint(32'h11019, 2, 24'h40, 24'h10, 20, 16'h8006, 3, 5, 1, 3);
    paint(32'h1101a, $urandom, 0, 0, 1, 1, 0, 9, 7, 2);
    for (int i = 0; i < 16; i++) begin
      c = $urandom;
      {c[14:13], c[9:8]} = i[3:0];
      {c[B_CLIP], c[B_TILE]} = i[1:0];
      {c[B_REPL], c[B_FAST]} = 2'b11;
      ef = (c[14:13] == 0 && !c[B_TILE] && !c[B_CLIP]) || (c[14:13] == 1 && !c[B_TPM]);
      apb(1'b1, A_CTRL, c);
      `CHK("rev", c[B_SWAP], copy_read_reverse)
      `CHK("mirror", c[B_MIRROR], copy_mirror)
      `CHK("half", c[B_HALF], copy_half_turn)
      `CHK("msrc", c[B_TPM], multi_source)
      `CHK("mdst", c[B_TPM+1], multi_dest)
      `CHK("fillm", c[B_FILLM], fill_missed)
      `CHK("put", c[B_PUT], put_transfer)
      `CHK("get", !c[B_PUT], get_transfer)
      `CHK("fast", ef, fast_active)
      apb(1'b0, A_STATUS, 32'h0);
      `CHK("stat_fast", ef, rd[1])
    end
    apb(1'b1, A_BCOL, 32'h3c3c_a5a5);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, A_CTRL, {29'h0, i[0], 2'b10});
      probe_colour <= i < 2 ? 16'ha5a5 : i < 4 ? 16'h3c3c : 16'($urandom);
      @(posedge clk);
      `CHK("bnd", i[0] ? probe_colour !== 16'h3c3c : probe_colour === 16'ha5a5, is_boundary)
    end
    test_done();
  end
endmodule
`default_nettype wire
